// ---- include/aor_defines.svh ----
`ifndef AOR_DEFINES_SVH
`define AOR_DEFINES_SVH

// ***************************************************
// Register offsets
// ***************************************************
`define AOR_ADDR_W 13
`define AOR_OFF_DRV_ADJ 13'h015
`define AOR_OFF_CLK_PHASE 13'h016
`define AOR_OFF_FULL_SCALE 13'h018
`define AOR_OFF_PAT1_LO 13'h019
`define AOR_OFF_PAT1_HI 13'h01a
`define AOR_OFF_PAT2_LO 13'h01b
`define AOR_OFF_PAT2_HI 13'h01c
`define AOR_OFF_SER_CTRL 13'h021
`define AOR_OFF_CHAN_STAT 13'h022
`define AOR_OFF_TRANSFER 13'h0ff
`define AOR_OFF_RES_RATE 13'h100
`define AOR_OFF_IO_CTRL2 13'h101
`define AOR_OFF_IO_CTRL3 13'h102

// ***************************************************
// Reset values
// ***************************************************
`define AOR_RST_DRV_ADJ 8'h00
`define AOR_RST_CLK_PHASE 8'h03
`define AOR_RST_FULL_SCALE 8'h04
`define AOR_RST_PATTERN 8'h00
`define AOR_RST_SER_CTRL 8'h32
`define AOR_RST_CHAN_STAT 2'h0
`define AOR_RST_RES_RATE 8'h00
`define AOR_RST_IO_CTRL 8'h00

// ***************************************************
// Field positions
// ***************************************************
`define AOR_DRV_DOUBLE_BIT 0
`define AOR_DRV_TERM_HI 5
`define AOR_DRV_TERM_LO 4
`define AOR_IN_PHASE_HI 6
`define AOR_IN_PHASE_LO 4
`define AOR_OUT_PHASE_HI 3
`define AOR_OUT_PHASE_LO 0
`define AOR_OUT_PHASE_MAX 4'hb
`define AOR_FS_HI 2
`define AOR_FS_LO 0
`define AOR_SER_LSB_FIRST_BIT 7
`define AOR_SER_MODE_HI 6
`define AOR_SER_MODE_LO 4
`define AOR_SER_LOW_ENC_BIT 3
`define AOR_SER_FRAME2X_BIT 2
`define AOR_SER_NBITS_HI 1
`define AOR_SER_NBITS_LO 0
`define AOR_CHAN_PD_BIT 0
`define AOR_CHAN_ORST_BIT 1
`define AOR_XFER_BIT 0
`define AOR_IO2_MASK 8'h01
`define AOR_IO3_MASK 8'h08
`define AOR_RES_RATE_MASK 8'h77
`define AOR_DRV_ADJ_MASK 8'h31
`define AOR_CLK_PHASE_MASK 8'h7f
`define AOR_FS_MASK 8'h07

`endif

// ---- include/aor_pkg.sv ----
package aor_pkg;
   typedef enum logic [2:0] {
      AOR_SER_SDR2_BIT  = 3'h0,
      AOR_SER_SDR2_BYTE = 3'h1,
      AOR_SER_DDR2_BIT  = 3'h2,
      AOR_SER_DDR2_BYTE = 3'h3,
      AOR_SER_DDR1_WORD = 3'h4
   } aor_ser_mode_t;
   typedef logic [12:0] aor_addr_t;
   typedef logic [7:0] aor_byte_t;
   typedef logic [15:0] aor_word_t;
endpackage : aor_pkg

// ---- include/aor_chan_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface aor_chan_if;
   logic wr;
   logic [1:0] wdata;
   logic pd;
   logic orst;
   modport ctrl (output wr, output wdata, input pd, input orst);
   modport slot (input wr, input wdata, output pd, output orst);
endinterface : aor_chan_if
`default_nettype wire

// ---- hdl/aor_chan_slot.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "aor_defines.svh"
module aor_chan_slot (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Channel carrier
   aor_chan_if.slot chan
);
   logic [1:0] stat_reg;
   logic [1:0] stat_next;

   // Local status only moves when this channel is addressed
   always_comb begin
      stat_next = stat_reg;
      if (chan.wr) begin
         stat_next = chan.wdata;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_reg <= `AOR_RST_CHAN_STAT;
      end else begin
         stat_reg <= stat_next;
      end
   end

   assign chan.pd = stat_reg[`AOR_CHAN_PD_BIT];
   assign chan.orst = stat_reg[`AOR_CHAN_ORST_BIT];

   chk_slot_write_lands: assert property (@(posedge core_clk) disable iff (sys_rst)
      chan.wr |=> stat_reg == $past(chan.wdata))
      else $error("channel status write not stored");
   chk_slot_holds_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
      !chan.wr |=> $stable(stat_reg))
      else $error("channel status changed without selection");
endmodule : aor_chan_slot
`default_nettype wire

// ---- hdl/aor_out_cfg_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "aor_defines.svh"
// Function
// - With clock divider in use, input clock phase field delays sampling by that many input clock cycles, else none; resets 0x03.
// - Output clock phase codes 0000..1011 only; higher codes are unsupported.
// - With clock divider in use, phase picks which divider phase drives output clock.
// - Output phase changes never move internal data latching timing.
// - Three-bit reference field selects full-scale span, 000..100; resets 0x04.
// - Two global 16-bit test words, low/high bytes at 0x19..0x1c, reset zero.
// - Three-bit serialization field picks lane mode; DDR two-lane bytewise at reset.
// - Encode mode bit: clear is normal rate, set is low encode rate.
// - Channel status holds power-down bit 0 and output reset bit 1, reset zero.
// - Override register acts only after transfer bit 0 written; others act at once.
// - Double drive applies only to frame and data clock outputs.
// - Termination selection overrides double drive on clock outputs.
// - Local fields hit only indexed channels; global fields hit all.
module aor_out_cfg_regs #(
   parameter int NUM_CHAN = 2
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register access from the serial control port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire aor_pkg::aor_addr_t reg_addr,
   input wire aor_pkg::aor_byte_t reg_wdata,
   output aor_pkg::aor_byte_t reg_rdata,
   output logic reg_rvalid,
   // Context from neighbouring registers
   input wire logic [1:0] chan_index,
   input wire logic [2:0] clk_div_ratio,
   // Clock path settings
   output logic [2:0] sample_phase_delay,
   output logic [3:0] out_clk_phase,
   output logic [3:0] div_phase_sel,
   output logic latch_phase_fixed,
   // Driver settings
   output logic [1:0] drv_termination,
   output logic frame_clock_output_double,
   output logic data_clock_output_double,
   output logic data_lane_double,
   // Reference and test words
   output logic [2:0] full_scale_sel,
   output aor_pkg::aor_word_t test_word_one,
   output aor_pkg::aor_word_t test_word_two,
   // Serializer settings
   output aor_pkg::aor_ser_mode_t ser_mode,
   output logic low_encode,
   output logic lsb_first,
   output logic frame_double,
   output logic [1:0] out_num_bits,
   // Per channel controls
   output logic [NUM_CHAN-1:0] chan_power_down,
   output logic [NUM_CHAN-1:0] chan_out_reset,
   // Override and pin controls
   output aor_pkg::aor_byte_t res_rate_active,
   output logic sdio_pulldown_off,
   output logic vcm_power_down
);
   import aor_pkg::*;

   // ***************************************************
   // Register state
   // ***************************************************
   aor_byte_t drv_reg, drv_next;
   aor_byte_t phase_reg, phase_next;
   aor_byte_t fs_reg, fs_next;
   aor_byte_t p1lo_reg, p1lo_next, p1hi_reg, p1hi_next;
   aor_byte_t p2lo_reg, p2lo_next, p2hi_reg, p2hi_next;
   aor_byte_t ser_reg, ser_next;
   aor_byte_t rr_shadow_reg, rr_shadow_next;
   aor_byte_t rr_active_reg, rr_active_next;
   aor_byte_t io2_reg, io2_next, io3_reg, io3_next;
   aor_byte_t rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic [NUM_CHAN-1:0] pd_q;
   logic [NUM_CHAN-1:0] orst_q;

   function automatic logic hit(input aor_addr_t a, input aor_addr_t off);
      hit = (a == off);
   endfunction

   function automatic logic phase_ok(input aor_byte_t d);
      phase_ok = (d[`AOR_OUT_PHASE_HI:`AOR_OUT_PHASE_LO] <= `AOR_OUT_PHASE_MAX);
   endfunction

   // ***************************************************
   // Per channel status slots
   // ***************************************************
   aor_chan_if chan_bus[NUM_CHAN] ();
   logic [NUM_CHAN-1:0] slot_pd, slot_orst;

   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      assign chan_bus[g].wr = reg_wr && hit(reg_addr, `AOR_OFF_CHAN_STAT)
                              && chan_index[g];
      assign chan_bus[g].wdata = reg_wdata[1:0];
      assign slot_pd[g] = chan_bus[g].pd;
      assign slot_orst[g] = chan_bus[g].orst;
      aor_chan_slot u_slot (
         .core_clk(core_clk),
         .sys_rst(sys_rst),
         .chan(chan_bus[g])
      );
   end

   // ***************************************************
   // Write side
   // ***************************************************
   // Global registers take a write at once; only the override waits
   always_comb begin
      drv_next = drv_reg;
      phase_next = phase_reg;
      fs_next = fs_reg;
      p1lo_next = p1lo_reg;
      p1hi_next = p1hi_reg;
      p2lo_next = p2lo_reg;
      p2hi_next = p2hi_reg;
      ser_next = ser_reg;
      rr_shadow_next = rr_shadow_reg;
      rr_active_next = rr_active_reg;
      io2_next = io2_reg;
      io3_next = io3_reg;
      if (reg_wr) begin
         if (hit(reg_addr, `AOR_OFF_DRV_ADJ)) begin
            drv_next = reg_wdata & `AOR_DRV_ADJ_MASK;
         end else if (hit(reg_addr, `AOR_OFF_CLK_PHASE)) begin
            // Unsupported output phase codes are dropped, keeping a legal phase
            if (phase_ok(reg_wdata)) begin
               phase_next = reg_wdata & `AOR_CLK_PHASE_MASK;
            end
         end else if (hit(reg_addr, `AOR_OFF_FULL_SCALE)) begin
            fs_next = reg_wdata & `AOR_FS_MASK;
         end else if (hit(reg_addr, `AOR_OFF_PAT1_LO)) begin
            p1lo_next = reg_wdata;
         end else if (hit(reg_addr, `AOR_OFF_PAT1_HI)) begin
            p1hi_next = reg_wdata;
         end else if (hit(reg_addr, `AOR_OFF_PAT2_LO)) begin
            p2lo_next = reg_wdata;
         end else if (hit(reg_addr, `AOR_OFF_PAT2_HI)) begin
            p2hi_next = reg_wdata;
         end else if (hit(reg_addr, `AOR_OFF_SER_CTRL)) begin
            ser_next = reg_wdata;
         end else if (hit(reg_addr, `AOR_OFF_TRANSFER)) begin
            if (reg_wdata[`AOR_XFER_BIT]) begin
               rr_active_next = rr_shadow_reg;
            end
         end else if (hit(reg_addr, `AOR_OFF_RES_RATE)) begin
            rr_shadow_next = reg_wdata & `AOR_RES_RATE_MASK;
         end else if (hit(reg_addr, `AOR_OFF_IO_CTRL2)) begin
            io2_next = reg_wdata & `AOR_IO2_MASK;
         end else if (hit(reg_addr, `AOR_OFF_IO_CTRL3)) begin
            io3_next = reg_wdata & `AOR_IO3_MASK;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         drv_reg <= `AOR_RST_DRV_ADJ;
         phase_reg <= `AOR_RST_CLK_PHASE;
         fs_reg <= `AOR_RST_FULL_SCALE;
         p1lo_reg <= `AOR_RST_PATTERN;
         p1hi_reg <= `AOR_RST_PATTERN;
         p2lo_reg <= `AOR_RST_PATTERN;
         p2hi_reg <= `AOR_RST_PATTERN;
         ser_reg <= `AOR_RST_SER_CTRL;
         rr_shadow_reg <= `AOR_RST_RES_RATE;
         rr_active_reg <= `AOR_RST_RES_RATE;
         io2_reg <= `AOR_RST_IO_CTRL;
         io3_reg <= `AOR_RST_IO_CTRL;
      end else begin
         drv_reg <= drv_next;
         phase_reg <= phase_next;
         fs_reg <= fs_next;
         p1lo_reg <= p1lo_next;
         p1hi_reg <= p1hi_next;
         p2lo_reg <= p2lo_next;
         p2hi_reg <= p2hi_next;
         ser_reg <= ser_next;
         rr_shadow_reg <= rr_shadow_next;
         rr_active_reg <= rr_active_next;
         io2_reg <= io2_next;
         io3_reg <= io3_next;
      end
   end

   // ***************************************************
   // Read side
   // ***************************************************
   // Local reads show the lowest indexed channel; none selected reads zero
   always_comb begin
      rdata_next = rdata_reg;
      rvalid_next = reg_rd;
      if (reg_rd) begin
         if (hit(reg_addr, `AOR_OFF_DRV_ADJ)) begin
            rdata_next = drv_reg;
         end else if (hit(reg_addr, `AOR_OFF_CLK_PHASE)) begin
            rdata_next = phase_reg;
         end else if (hit(reg_addr, `AOR_OFF_FULL_SCALE)) begin
            rdata_next = fs_reg;
         end else if (hit(reg_addr, `AOR_OFF_PAT1_LO)) begin
            rdata_next = p1lo_reg;
         end else if (hit(reg_addr, `AOR_OFF_PAT1_HI)) begin
            rdata_next = p1hi_reg;
         end else if (hit(reg_addr, `AOR_OFF_PAT2_LO)) begin
            rdata_next = p2lo_reg;
         end else if (hit(reg_addr, `AOR_OFF_PAT2_HI)) begin
            rdata_next = p2hi_reg;
         end else if (hit(reg_addr, `AOR_OFF_SER_CTRL)) begin
            rdata_next = ser_reg;
         end else if (hit(reg_addr, `AOR_OFF_CHAN_STAT)) begin
            rdata_next = 8'h00;
            for (int i = NUM_CHAN - 1; i >= 0; i--) begin
               if (chan_index[i]) begin
                  rdata_next = {6'h00, slot_orst[i], slot_pd[i]};
               end
            end
         end else if (hit(reg_addr, `AOR_OFF_RES_RATE)) begin
            rdata_next = rr_shadow_reg;
         end else if (hit(reg_addr, `AOR_OFF_IO_CTRL2)) begin
            rdata_next = io2_reg;
         end else if (hit(reg_addr, `AOR_OFF_IO_CTRL3)) begin
            rdata_next = io3_reg;
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // ***************************************************
   // Registered outputs
   // ***************************************************
   // Channel, clock path and driver outputs lag their register by one edge; other ports read the registers directly
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pd_q <= '0;
         orst_q <= '0;
      end else begin
         pd_q <= slot_pd;
         orst_q <= slot_orst;
      end
   end

   logic dbl_req;
   logic term_on;
   logic div_used;
   assign dbl_req = drv_reg[`AOR_DRV_DOUBLE_BIT];
   assign term_on = |drv_reg[`AOR_DRV_TERM_HI:`AOR_DRV_TERM_LO];
   assign div_used = |clk_div_ratio;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sample_phase_delay <= 3'h0;
         out_clk_phase <= 4'h3;
         div_phase_sel <= 4'h0;
         latch_phase_fixed <= 1'b1;
         drv_termination <= 2'h0;
         frame_clock_output_double <= 1'b0;
         data_clock_output_double <= 1'b0;
         data_lane_double <= 1'b0;
      end else begin
         // Input phase only means something while the divider runs
         sample_phase_delay <= div_used ? phase_reg[`AOR_IN_PHASE_HI:`AOR_IN_PHASE_LO] : 3'h0;
         out_clk_phase <= phase_reg[`AOR_OUT_PHASE_HI:`AOR_OUT_PHASE_LO];
         div_phase_sel <= div_used ? phase_reg[`AOR_OUT_PHASE_HI:`AOR_OUT_PHASE_LO] : 4'h0;
         latch_phase_fixed <= 1'b1;
         drv_termination <= drv_reg[`AOR_DRV_TERM_HI:`AOR_DRV_TERM_LO];
         frame_clock_output_double <= dbl_req && !term_on;
         data_clock_output_double <= dbl_req && !term_on;
         data_lane_double <= 1'b0;
      end
   end

   assign full_scale_sel = fs_reg[`AOR_FS_HI:`AOR_FS_LO];
   assign test_word_one = {p1hi_reg, p1lo_reg};
   assign test_word_two = {p2hi_reg, p2lo_reg};
   assign ser_mode = aor_ser_mode_t'(ser_reg[`AOR_SER_MODE_HI:`AOR_SER_MODE_LO]);
   assign low_encode = ser_reg[`AOR_SER_LOW_ENC_BIT];
   assign lsb_first = ser_reg[`AOR_SER_LSB_FIRST_BIT];
   assign frame_double = ser_reg[`AOR_SER_FRAME2X_BIT];
   assign out_num_bits = ser_reg[`AOR_SER_NBITS_HI:`AOR_SER_NBITS_LO];
   assign chan_power_down = pd_q;
   assign chan_out_reset = orst_q;
   assign res_rate_active = rr_active_reg;
   assign sdio_pulldown_off = io2_reg[0];
   assign vcm_power_down = io3_reg[3];
   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   chk_phase_code_legal: assert property (
      out_clk_phase <= `AOR_OUT_PHASE_MAX)
      else $error("output clock phase above supported range");
   chk_phase_bad_kept: assert property (
      reg_wr && hit(reg_addr, `AOR_OFF_CLK_PHASE) && !phase_ok(reg_wdata) |=> $stable(phase_reg))
      else $error("unsupported phase code was stored");
   chk_sample_delay_div: assert property (
      reg_wr && hit(reg_addr, `AOR_OFF_CLK_PHASE) && phase_ok(reg_wdata) && div_used
      ##1 div_used |=> sample_phase_delay == $past(reg_wdata[6:4], 2))
      else $error("sample delay does not follow input phase field");
   chk_div_phase_pick: assert property (
      !div_used |=> div_phase_sel == 4'h0)
      else $error("divider phase chosen without divider");
   chk_latch_unmoved: assert property (
      $changed(out_clk_phase) |-> latch_phase_fixed)
      else $error("data latch timing moved with output phase");
   chk_override_waits: assert property (
      reg_wr && hit(reg_addr, `AOR_OFF_RES_RATE) |=> $stable(res_rate_active))
      else $error("override took effect before transfer");
   chk_override_xfer: assert property (
      reg_wr && hit(reg_addr, `AOR_OFF_TRANSFER) && reg_wdata[0] |=>
      res_rate_active == $past(rr_shadow_reg))
      else $error("transfer did not apply override");
   chk_term_precedence: assert property (
      term_on |=> !frame_clock_output_double && !data_clock_output_double)
      else $error("double drive active with termination");
   chk_drive_clocks_only: assert property (
      dbl_req && !term_on |=> frame_clock_output_double && !data_lane_double)
      else $error("double drive not limited to clock outputs");
   chk_pattern_write: assert property (
      reg_wr && hit(reg_addr, `AOR_OFF_PAT2_HI) |=> test_word_two[15:8] == $past(reg_wdata))
      else $error("test word high byte not stored");
   chk_serial_fields: assert property (
      reg_wr && hit(reg_addr, `AOR_OFF_SER_CTRL) |=>
      ser_mode == aor_ser_mode_t'($past(reg_wdata[6:4])) && lsb_first == $past(reg_wdata[7])
      && low_encode == $past(reg_wdata[3]))
      else $error("serializer settings not applied at once");
   chk_chan_unselected: assert property (
      reg_wr && hit(reg_addr, `AOR_OFF_CHAN_STAT) && !chan_index[0] |=> ##1 $stable(chan_power_down[0]))
      else $error("unselected channel changed");
   chk_read_answer: assert property (
      reg_rd && hit(reg_addr, `AOR_OFF_FULL_SCALE) |=> reg_rvalid && reg_rdata == $past(fs_reg))
      else $error("reference read back wrong");
endmodule : aor_out_cfg_regs
`default_nettype wire

// ---- tb/aor_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************
// Control port host
// ****************
module aor_host_model (
   // Clock
   input wire logic core_clk,
   // Register access
   output aor_pkg::aor_addr_t reg_addr,
   output aor_pkg::aor_byte_t reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire aor_pkg::aor_byte_t reg_rdata,
   input wire logic reg_rvalid
);
   import aor_pkg::*;
   initial begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Released lines flip so a stale value never looks valid
   task automatic wr(input aor_addr_t a, input aor_byte_t d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input aor_addr_t a, output aor_byte_t d, output logic v);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
      v = reg_rvalid;
   endtask
   // Slow sampling needs DDR one-lane and low encode together
   task automatic low_rate_setup();
      wr(13'h021, 8'h48);
   endtask
endmodule // aor_host_model
`default_nettype wire

// ---- tb/adc_output_config_registers_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************
// Bench top
// ****************
module adc_output_config_registers_tb_top;
   import aor_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [1:0] chan_index = 2'h0;
   logic [2:0] clk_div_ratio = 3'h0;
   aor_addr_t reg_addr;
   aor_byte_t reg_wdata, reg_rdata, res_rate_active;
   logic reg_wr, reg_rd, reg_rvalid, latch_phase_fixed, low_encode, lsb_first;
   logic frame_clk_dbl, data_clk_dbl, lane_dbl, frame_double, sdio_pulldown_off, vcm_power_down;
   logic [2:0] sample_phase_delay, full_scale_sel;
   logic [3:0] out_clk_phase, div_phase_sel;
   logic [1:0] drv_termination, out_num_bits, pd, orst;
   aor_word_t test_word_one, test_word_two;
   aor_ser_mode_t ser_mode;
   int err_count = 0;
   int n_compared = 0;
   logic [12:0] ra [13] = '{13'h015, 13'h016, 13'h018, 13'h019, 13'h01a, 13'h01b, 13'h01c,
      13'h021, 13'h022, 13'h100, 13'h101, 13'h102, 13'h000};
   logic [7:0] re [13] = '{8'h00, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h32, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00};
   always #20 core_clk = ~core_clk;
   aor_host_model i_aor_host_model (.core_clk(core_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   aor_out_cfg_regs #(.NUM_CHAN(2)) i_aor_out_cfg_regs (.core_clk(core_clk),
      .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .chan_index(chan_index), .clk_div_ratio(clk_div_ratio),
      .sample_phase_delay(sample_phase_delay), .out_clk_phase(out_clk_phase),
      .div_phase_sel(div_phase_sel), .latch_phase_fixed(latch_phase_fixed),
      .drv_termination(drv_termination), .frame_clock_output_double(frame_clk_dbl),
      .data_clock_output_double(data_clk_dbl), .data_lane_double(lane_dbl),
      .full_scale_sel(full_scale_sel), .test_word_one(test_word_one),
      .test_word_two(test_word_two), .ser_mode(ser_mode), .low_encode(low_encode),
      .lsb_first(lsb_first), .frame_double(frame_double), .out_num_bits(out_num_bits),
      .chan_power_down(pd), .chan_out_reset(orst), .res_rate_active(res_rate_active),
      .sdio_pulldown_off(sdio_pulldown_off), .vcm_power_down(vcm_power_down));
   // ****************
   // Shared tasks
   // ****************
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rchk(input aor_addr_t a, input aor_byte_t e);
      aor_byte_t d;
      logic v;
      i_aor_host_model.rd(a, d, v);
      cmp(v, 1'b1);
      cmp(d, e);
   endtask
   // Derived and channel outputs both lag their register by one edge
   task automatic settle();
      repeat (2) @(negedge core_clk);
   endtask
   task automatic final_report();
      if (err_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      for (int i = 0; i < 13; i++) begin
         rchk(ra[i], re[i]);
      end
      cmp(ser_mode, 16'h3);
      cmp({low_encode, lsb_first}, 16'h0);
      cmp(full_scale_sel, 16'h4);
      cmp({frame_double, out_num_bits}, 16'h2);
      cmp({sdio_pulldown_off, vcm_power_down}, 16'h0);
   endtask
   task automatic t_phase();
      i_aor_host_model.wr(13'h016, 8'h5b);
      settle();
      cmp(out_clk_phase, 16'hb);
      cmp(sample_phase_delay, 16'h0);
      cmp(div_phase_sel, 16'h0);
      clk_div_ratio = 3'h7;
      settle();
      cmp(sample_phase_delay, 16'h5);
      cmp(div_phase_sel, 16'hb);
      cmp(latch_phase_fixed, 16'h1);
      i_aor_host_model.wr(13'h016, 8'h0c);
      settle();
      rchk(13'h016, 8'h5b);
   endtask
   task automatic t_drive();
      i_aor_host_model.wr(13'h015, 8'h01);
      settle();
      cmp({frame_clk_dbl, data_clk_dbl, lane_dbl}, 16'h6);
      i_aor_host_model.wr(13'h015, 8'h11);
      settle();
      cmp({frame_clk_dbl, data_clk_dbl, drv_termination}, 16'h1);
   endtask
   task automatic t_words();
      i_aor_host_model.wr(13'h019, 8'ha5);
      i_aor_host_model.wr(13'h01a, 8'h3c);
      i_aor_host_model.wr(13'h01b, 8'h0f);
      i_aor_host_model.wr(13'h01c, 8'hf0);
      i_aor_host_model.wr(13'h018, 8'h00);
      cmp(test_word_one, 16'h3ca5);
      cmp(test_word_two, 16'hf00f);
      cmp(full_scale_sel, 16'h0);
      i_aor_host_model.wr(13'h101, 8'hff);
      i_aor_host_model.wr(13'h102, 8'hff);
      cmp({sdio_pulldown_off, vcm_power_down}, 16'h3);
      rchk(13'h102, 8'h08);
   endtask
   task automatic t_ser();
      for (int m = 0; m < 5; m++) begin
         i_aor_host_model.wr(13'h021, {1'b1, 3'(m), 4'h0});
         cmp(ser_mode, 16'(m));
         cmp({lsb_first, low_encode}, 16'h2);
      end
      i_aor_host_model.wr(13'h021, 8'h37);
      cmp({frame_double, out_num_bits}, 16'h7);
      i_aor_host_model.low_rate_setup();
      cmp({ser_mode, lsb_first, low_encode}, 16'h11);
   endtask
   task automatic t_override();
      i_aor_host_model.wr(13'h100, 8'h45);
      settle();
      cmp(res_rate_active, 16'h0);
      rchk(13'h100, 8'h45);
      i_aor_host_model.wr(13'h0ff, 8'h01);
      settle();
      cmp(res_rate_active, 16'h45);
   endtask
   task automatic t_chan();
      chan_index = 2'h1;
      i_aor_host_model.wr(13'h022, 8'h03);
      settle();
      cmp({pd, orst}, 16'h5);
      rchk(13'h022, 8'h03);
      chan_index = 2'h2;
      i_aor_host_model.wr(13'h022, 8'h01);
      settle();
      cmp({pd, orst}, 16'hd);
      chan_index = 2'h0;
      i_aor_host_model.wr(13'h022, 8'h00);
      settle();
      cmp({pd, orst}, 16'hd);
   endtask
   initial begin
      repeat (2) @(negedge core_clk);
      sys_rst = 1'b0;
      t_reset();
      t_phase();
      t_drive();
      t_words();
      t_ser();
      t_override();
      t_chan();
      final_report();
   end
   initial begin
      #100000;
      err_count++;
      final_report();
   end
endmodule // adc_output_config_registers_tb_top
`default_nettype wire
